// *** dv/eec_event_src.sv ***
// Pulse source standing on the event pin of the counter.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module eec_event_src (
   // Clock
   input wire logic clk,
   // Event pin
   output logic pin
);
   // Idle high, so reset release never looks like a falling edge
   initial pin = 1'b1;

   // Each level is held at least two cycles so the synchroniser sees it
   task automatic pulses(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge clk);
         pin <= 1'b0;
         repeat (half) @(posedge clk);
         pin <= 1'b1;
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic level(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (6) @(posedge clk);
   endtask
endmodule // eec_event_src
`default_nettype wire

// *** dv/external_event_counter_tb_top.sv ***
// Self-checking bench for the external event counter.
// Assumes the pulse source model and an APB slave answering with pready.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module external_event_counter_tb_top;
   import eec_pkg::*;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, err, event_pin, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [7:0] prev;
   int fails, n_compared, cyc, n;

   eec_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_pin(event_pin), .irq(irq));
   eec_event_src src (.clk(clk), .pin(event_pin));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard: the whole run needs under two thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [15:0] idx,
         input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      // Wait as long as the slave needs; the hang guard ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      `CHK(rd, {24'h000000, e})
   endtask

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      void'($urandom(32'he8b8c61f));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rchk(IDX_MODE, 8'h7e);
      rchk(IDX_COUNT, 8'h00);
      apb(1'b0, 16'h1234, 8'h00);
      `CHK(err, 1'b1)
      $display("test reset done");
      apb(1'b1, IDX_PORT_MODE, 8'h01);
      apb(1'b1, IDX_MODE, 8'h00);
      n = $urandom_range(20, 1);
      src.pulses(n, $urandom_range(5, 2));
      rchk(IDX_COUNT, n[7:0]);
      apb(1'b1, IDX_COUNT, 8'h55);
      rchk(IDX_COUNT, n[7:0]);
      $display("test falling done");
      // Edge change may count once, so clear again afterwards
      apb(1'b1, IDX_MODE, 8'h81);
      apb(1'b1, IDX_MODE, 8'h81);
      rchk(IDX_COUNT, 8'h00);
      rchk(IDX_MODE, 8'h7f);
      src.pulses(3, 2);
      rchk(IDX_COUNT, 8'h03);
      apb(1'b1, IDX_MODE, 8'h01);
      rchk(IDX_COUNT, 8'h03);
      src.level(1'b0);
      rchk(IDX_COUNT, 8'h03);
      src.level(1'b1);
      rchk(IDX_COUNT, 8'h04);
      $display("test rising done");
      apb(1'b1, IDX_IRQ_EN, 8'h01);
      src.pulses(252, 2);
      rchk(IDX_COUNT, 8'h00);
      rchk(IDX_IRQ_REQ, 8'h01);
      `CHK(irq, 1'b1)
      src.pulses(1, 3);
      rchk(IDX_COUNT, 8'h01);
      apb(1'b1, IDX_IRQ_EN, 8'h00);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(1'b1, IDX_IRQ_REQ, 8'h01);
      rchk(IDX_IRQ_REQ, 8'h00);
      $display("test overflow done");
      prev = 8'h01;
      fork
         src.pulses(30, $urandom_range(4, 2));
         repeat (12) begin
            apb(1'b0, IDX_COUNT, 8'h00);
            `CHK(rd[7:0] >= prev, 1'b1)
            prev = rd[7:0];
         end
      join
      rchk(IDX_COUNT, 8'h1f);
      $display("test live read done");
      close_out();
   end
endmodule // external_event_counter_tb_top
`default_nettype wire

// *** rtl/eec_counter.sv ***
// Wrapping up-counter with synchronous clear and a wrap pulse.
// Assumes count and clear come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module eec_counter
   import eec_pkg::*;
#(
   parameter int W = CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic count_en,
   input wire logic clear,
   // State
   output logic [W-1:0] count,
   output logic wrap_pulse
);
   logic [W-1:0] cnt_reg, cnt_next;
   logic wrap_reg, wrap_next;

   // Clear wins over a coincident edge; that edge is dropped
   always_comb begin
      cnt_next = cnt_reg;
      wrap_next = 1'b0;
      if (clear) begin
         cnt_next = W'(COUNT_RESET); // RULE_06
      end else if (count_en) begin
         cnt_next = cnt_reg + W'(1); // RULE_01 RULE_05
         wrap_next = (cnt_reg == {W{1'b1}}); // RULE_03
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= W'(COUNT_RESET); // RULE_09
         wrap_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         wrap_reg <= wrap_next;
      end
   end

   assign count = cnt_reg;
   assign wrap_pulse = wrap_reg;
endmodule // eec_counter
`default_nettype wire

// *** rtl/eec_edge_sync.sv ***
// Event pin synchroniser and edge detector.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module eec_edge_sync
   import eec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pin and control
   input wire logic pin_in,
   input wire logic rise_sel,
   // Result
   output logic edge_pulse
);
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic prev_reg, prev_next;

   always_comb begin
      meta_next = pin_in;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   // Idle level high so a pin resting high gives no edge after reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // One pulse per edge from two successive synchronised samples
   assign edge_pulse = (sync_reg == rise_sel) && (prev_reg != rise_sel); // RULE_12 RULE_02

   a_edge_select: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
      edge_pulse |-> (sync_reg == rise_sel) && $past(sync_reg) != rise_sel)
      else $error("edge pulse on the wrong edge");
   a_edge_single: assert property (@(posedge clk) disable iff (!nrst) // RULE_12
      edge_pulse && $stable(rise_sel) |=> !edge_pulse)
      else $error("edge pulse longer than one cycle");
endmodule // eec_edge_sync
`default_nettype wire

// *** rtl/eec_pkg.sv ***
// Constants shared by the external event counter and its helpers.
// Assumes one 125 MHz clock and a 32-bit APB bus with word registers.
// Contract
// RULE_01: Eight-bit up-counter advances once per selected pin edge; software only reads it.
// RULE_02: Mode bit 0 picks the edge: zero falling (reset), one rising.
// RULE_03: Wrap from ff to 00 sets the overflow request flag.
// RULE_04: Interrupt raised while overflow flag and its enable bit are both set.
// RULE_05: After overflow the count sits at 00 and keeps counting on.
// RULE_06: Writing one to the clear bit zeroes the count; the bit self-clears.
// RULE_07: Mode bit 7 acts only when written one; writing zero does nothing.
// RULE_08: Mode bits 6 to 1 always read one and ignore writes.
// RULE_09: Reset zeroes the count and selects the falling edge.
// RULE_10: The count can be read at any time without disturbing counting.
// RULE_11: Software enables the event pin function before expecting any counting.
// RULE_12: Pin is synchronised; two samples give one count pulse per edge.
package eec_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int CNT_W = 8;

   // Register indices; the byte address is four times the index
   localparam logic [15:0] IDX_MODE = 16'hffc6;
   localparam logic [15:0] IDX_COUNT = 16'hffc7;
   localparam logic [15:0] IDX_IRQ_REQ = 16'hffd0;
   localparam logic [15:0] IDX_IRQ_EN = 16'hffd1;
   localparam logic [15:0] IDX_PORT_MODE = 16'hffd2;

   localparam int MODE_EDGE_BIT = 0;
   localparam int MODE_CLR_BIT = 7;
   localparam logic [7:0] MODE_RSVD_ONES = 8'h7e;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam int IRQ_OVF_BIT = 0;
   localparam int PORT_EVENT_BIT = 0;

   localparam logic EDGE_FALL = 1'b0;
   localparam logic EDGE_RISE = 1'b1;

   typedef enum logic [0:0] {
      BUS_WAIT = 1'b0,
      BUS_DONE = 1'b1
   } eec_bus_t;
endpackage

// *** rtl/eec_top.sv ***
// External event counter: APB register slave, pin edge counting,
// overflow flag and interrupt.
// Assumes an APB master on clk and an asynchronous event pin.
`timescale 1ns/1ps
`default_nettype none
module eec_top
   import eec_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event pin
   input wire logic event_pin,
   // Interrupt
   output logic irq
);
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [15:0] idx);
      addr_is = (a == {idx, 2'b00});
   endfunction

   // Bus state
   eec_bus_t bus_reg, bus_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic err_reg, err_next;

   // Register state
   logic edge_sel_reg, edge_sel_next;
   logic clr_reg, clr_next;
   logic flag_reg, flag_next;
   logic irq_en_reg, irq_en_next;
   logic pin_fn_reg, pin_fn_next;
   logic irq_reg, irq_next;

   // Decoded strobes
   logic access;
   logic wr_fire;
   logic sel_mode, sel_count, sel_req, sel_en, sel_port;
   logic mapped;
   logic wr_mode, wr_req, wr_en, wr_port;
   logic clear_cmd;
   logic [7:0] mode_view;
   logic [7:0] count_val;
   logic edge_pulse;
   logic count_en;
   logic wrap_pulse;

   // Every register decodes one full word address; byte lanes are unused
   assign access = psel && penable;
   assign sel_mode = addr_is(paddr, IDX_MODE);
   assign sel_count = addr_is(paddr, IDX_COUNT);
   assign sel_req = addr_is(paddr, IDX_IRQ_REQ);
   assign sel_en = addr_is(paddr, IDX_IRQ_EN);
   assign sel_port = addr_is(paddr, IDX_PORT_MODE);
   assign mapped = sel_mode || sel_count || sel_req || sel_en || sel_port;

   // A write lands at the edge where the master sees pready high
   assign wr_fire = access && pwrite && (bus_reg == BUS_DONE) && mapped;
   assign wr_mode = wr_fire && sel_mode;
   assign wr_req = wr_fire && sel_req;
   assign wr_en = wr_fire && sel_en;
   assign wr_port = wr_fire && sel_port;

   // Only a written one clears; a zero in bit 7 is ignored
   assign clear_cmd = wr_mode && pwdata[MODE_CLR_BIT]; // RULE_07 RULE_06

   // Reserved bits forced to one regardless of writes
   always_comb begin
      mode_view = MODE_RSVD_ONES; // RULE_08
      mode_view[MODE_CLR_BIT] = clr_reg;
      mode_view[MODE_EDGE_BIT] = edge_sel_reg;
   end

   // Bus: pready one cycle into the access phase, read data latched then
   always_comb begin
      bus_next = BUS_WAIT;
      rdata_next = rdata_reg;
      err_next = 1'b0;
      if (access && bus_reg == BUS_WAIT) begin
         bus_next = BUS_DONE;
         err_next = !mapped;
         rdata_next = '0;
         // Writes leave read data zero so a stale value never looks fresh
         if (!pwrite) begin
            unique case (1'b1)
               sel_mode:
                  rdata_next[7:0] = mode_view;
               sel_count:
                  rdata_next[7:0] = count_val; // RULE_10
               sel_req:
                  rdata_next[IRQ_OVF_BIT] = flag_reg;
               sel_en:
                  rdata_next[IRQ_OVF_BIT] = irq_en_reg;
               sel_port:
                  rdata_next[PORT_EVENT_BIT] = pin_fn_reg;
               default:
                  rdata_next = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_reg <= BUS_WAIT;
         rdata_reg <= '0;
         err_reg <= 1'b0;
      end else begin
         bus_reg <= bus_next;
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign pready = (bus_reg == BUS_DONE);
   assign prdata = rdata_reg;
   assign pslverr = err_reg;

   // Control and interrupt registers
   always_comb begin
      edge_sel_next = edge_sel_reg;
      irq_en_next = irq_en_reg;
      pin_fn_next = pin_fn_reg;
      if (wr_mode) begin
         edge_sel_next = pwdata[MODE_EDGE_BIT]; // RULE_02
      end
      if (wr_en) begin
         irq_en_next = pwdata[IRQ_OVF_BIT];
      end
      if (wr_port) begin
         pin_fn_next = pwdata[PORT_EVENT_BIT];
      end
      // Clear bit reads one only for the cycle after the command
      clr_next = clear_cmd; // RULE_06
      // Set wins over a coincident write-one-to-clear
      flag_next = wrap_pulse ||
                  (flag_reg && !(wr_req && pwdata[IRQ_OVF_BIT])); // RULE_03
      // One cycle of lag keeps irq a plain flip-flop output
      irq_next = flag_reg && irq_en_reg; // RULE_04
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         edge_sel_reg <= EDGE_FALL; // RULE_09
         clr_reg <= 1'b0;
         flag_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         pin_fn_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         edge_sel_reg <= edge_sel_next;
         clr_reg <= clr_next;
         flag_reg <= flag_next;
         irq_en_reg <= irq_en_next;
         pin_fn_reg <= pin_fn_next;
         irq_reg <= irq_next;
      end
   end

   assign irq = irq_reg;

   eec_edge_sync u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin_in(event_pin),
      .rise_sel(edge_sel_reg),
      .edge_pulse(edge_pulse)
   );

   // Pin edges count only once software hands the pin to the counter
   assign count_en = edge_pulse && pin_fn_reg; // RULE_11

   // Clear comes straight from the bus decode, so the count already
   // reads zero in the cycle after the write edge
   eec_counter #(
      .W(CNT_W)
   ) u_count (
      .clk(clk),
      .nrst(nrst),
      .count_en(count_en),
      .clear(clear_cmd),
      .count(count_val),
      .wrap_pulse(wrap_pulse)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_count_step: assert property ( // RULE_01
      count_en && !clear_cmd |=> count_val == $past(count_val) + 8'h01)
      else $error("count did not advance by one");
   a_count_hold: assert property ( // RULE_10
      !count_en && !clear_cmd |=> $stable(count_val))
      else $error("count changed without an edge");
   a_wrap_flag: assert property ( // RULE_03
      count_en && !clear_cmd && count_val == COUNT_MAX
      |=> count_val == COUNT_RESET ##1 flag_reg)
      else $error("wrap did not set the overflow flag");
   a_wrap_goes_on: assert property ( // RULE_05
      wrap_pulse |-> count_val == COUNT_RESET)
      else $error("count not zero after wrap");
   a_irq_level: assert property ( // RULE_04
      ##1 irq == $past(flag_reg && irq_en_reg))
      else $error("interrupt does not follow flag and enable");
   a_clear_zero: assert property ( // RULE_06
      clear_cmd |=> count_val == COUNT_RESET && clr_reg ##1 !clr_reg)
      else $error("clear did not zero count or self-clear");
   a_zero_ignored: assert property ( // RULE_07
      wr_mode && !pwdata[MODE_CLR_BIT] && !count_en |=> $stable(count_val))
      else $error("writing zero to the clear bit had an effect");
   a_rsvd_ones: assert property ( // RULE_08
      pready && !pwrite && sel_mode |-> prdata[6:1] == MODE_RSVD_ONES[6:1])
      else $error("reserved mode bits not read as one");
   a_reset_state: assert property ( // RULE_09
      $rose(nrst) |-> count_val == COUNT_RESET && edge_sel_reg == EDGE_FALL)
      else $error("reset values wrong");
   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   // Register bus timing and decode
   a_ready_next: assert property (
      access && !pready |=> pready)
      else $error("pready did not follow the access phase");
   a_err_decode: assert property (
      pready |-> pslverr == !mapped)
      else $error("pslverr does not match the address decode");
   a_err_pulse: assert property (
      pslverr |-> pready)
      else $error("pslverr without pready");
   a_read_upper: assert property (
      pready && !pwrite |-> prdata[DATA_W-1:8] == '0)
      else $error("upper read data bits not zero");
   a_read_count: assert property ( // RULE_10
      pready && !pwrite && sel_count |-> prdata[7:0] == $past(count_val))
      else $error("count read does not match the count");
   a_read_edge: assert property ( // RULE_02
      pready && !pwrite && sel_mode
      |-> prdata[MODE_EDGE_BIT] == $past(edge_sel_reg))
      else $error("edge select read back wrong");
   a_count_ro: assert property ( // RULE_01
      wr_fire && sel_count && !count_en |=> $stable(count_val))
      else $error("a write changed the count");

   // Edge select, clear and pin gating
   a_edge_write: assert property ( // RULE_02
      wr_mode |=> edge_sel_reg == $past(pwdata[MODE_EDGE_BIT]))
      else $error("edge select not written");
   a_edge_keep: assert property ( // RULE_02
      !wr_mode |=> $stable(edge_sel_reg))
      else $error("edge select changed without a write");
   a_clr_idle: assert property ( // RULE_06
      !clear_cmd |=> !clr_reg)
      else $error("clear bit reads one without a clear");
   a_clear_wins: assert property ( // RULE_06
      clear_cmd && count_en |=> count_val == COUNT_RESET)
      else $error("coincident edge beat the clear");
   a_pin_gated: assert property ( // RULE_11
      !pin_fn_reg && !clear_cmd |=> $stable(count_val))
      else $error("count moved with the pin function off");

   // Overflow flag and interrupt
   a_flag_set: assert property ( // RULE_03
      wrap_pulse |=> flag_reg)
      else $error("wrap did not set the flag");
   a_flag_keep: assert property ( // RULE_03
      flag_reg && !(wr_req && pwdata[IRQ_OVF_BIT]) |=> flag_reg)
      else $error("flag lost without a clear");
   a_flag_w1c: assert property ( // RULE_03
      flag_reg && wr_req && pwdata[IRQ_OVF_BIT] && !wrap_pulse |=> !flag_reg)
      else $error("writing one did not clear the flag");
   a_flag_quiet: assert property ( // RULE_03
      !flag_reg && !wrap_pulse |=> !flag_reg)
      else $error("flag set without a wrap");
   a_irq_masked: assert property ( // RULE_04
      !irq_en_reg |=> !irq)
      else $error("interrupt raised while disabled");
   a_reset_flags: assert property ( // RULE_09
      $rose(nrst) |-> !flag_reg && !irq && !clr_reg)
      else $error("flags not clear after reset");

   c_overflow: cover property (wrap_pulse);
   c_clear: cover property (clear_cmd && count_val != COUNT_RESET);
   c_irq: cover property ($rose(irq));
   c_rise_count: cover property (count_en && edge_sel_reg == EDGE_RISE);
   c_flag_clear: cover property (wr_req && pwdata[IRQ_OVF_BIT] && flag_reg);
endmodule // eec_top
`default_nettype wire
